// file: src/xlate_ops_pkg.sv
// constants, encodings and state layout of the global address translation command bank
package xlate_ops_pkg;

  // ==========================================================================
  // register map (byte offsets inside the block's window)
  localparam int unsigned NUM_CMDS = 6;
  localparam logic [7:0] OFS_CMD_BASE = 8'h00;
  localparam logic [7:0] OFS_CMD_END = 8'h30;
  localparam logic [7:0] OFS_RESULT_LO = 8'h30;
  localparam logic [7:0] OFS_RESULT_HI = 8'h34;
  localparam logic [7:0] OFS_STATUS = 8'h38;
  localparam int unsigned OFS_ALIAS_BIT = 6;
  localparam int unsigned OFS_OUT_BIT = 7;
  localparam int unsigned CMD_HI_BIT = 2;
  localparam int unsigned CMD_IDX_LSB = 3;

  // ==========================================================================
  // field positions and widths
  localparam int unsigned ADDR_LSB = 12;
  localparam int unsigned NDX_MSB = 7;
  localparam int unsigned STATUS_ACTIVE_BIT = 0;
  localparam int unsigned WIDE_IA_W = 52;
  localparam int unsigned NARROW_IA_W = 20;

  // ==========================================================================
  // reset values
  localparam logic [63:0] RESULT_RST = 64'h0;
  localparam logic [31:0] RDATA_RST = 32'h0;
  localparam logic [1:0] ACTIVE_RST = 2'h0;

  // ==========================================================================
  // banks, bus codes, commands and engine states
  localparam logic BANK_SEC = 1'b0;
  localparam logic BANK_NS = 1'b1;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

  typedef enum logic [2:0] {
    CMD_S1_PRIV_READ = 3'b000,
    CMD_S1_PRIV_WRITE = 3'b001,
    CMD_S1_UNPRIV_READ = 3'b010,
    CMD_S1_UNPRIV_WRITE = 3'b011,
    CMD_S12_PRIV_READ = 3'b100,
    CMD_S12_PRIV_WRITE = 3'b101
  } cmd_e;

  typedef enum logic [1:0] {
    ENG_IDLE = 2'b00,
    ENG_REQ = 2'b01,
    ENG_WAIT = 2'b10
  } eng_e;

  typedef struct packed {
    logic wr_pend;
    logic [7:0] wr_off;
    logic wr_ns;
    logic [31:0] rdata;
    eng_e eng;
    logic [1:0] active;
    logic [63:0] res_sec;
    logic [63:0] res_ns;
    logic req_bank;
    logic [WIDE_IA_W-1:0] req_addr;
    logic [7:0] req_ndx;
    cmd_e req_cmd;
  } state_s;

endpackage : xlate_ops_pkg

// file: src/xlate_ops.sv
// global address translation command registers with AHB-Lite slave and engine request port
// Contract
// - a 32-bit write to a command's low word is taken as 64 bits, upper zero.
// - a 32-bit write to a command's high word does nothing.
// - a low-word command write made while none is active starts a translation; the outcome lands in the result register.
// - wide form: 64-bit write-only, address 63:12, reserved 11:8, bank index 7:0.
// - narrow form: 32-bit write-only, address field in bits 31:12.
// - bits 7:0 of the written value pick the stage 1 context bank.
// - stage 1 privileged read command translates with stage 1 only, privileged read.
// - combined privileged read command translates stage 1 then stage 2, privileged read.
// - privileged write commands, both forms, translate as a privileged write.
// - privileged read commands translate as a privileged read.
// - stage 1 unprivileged read command translates as an unprivileged read.
// - stage 1 unprivileged write command translates as an unprivileged write.
// - the access's security state picks the secure or non-secure register copy.
// - secure software can write the non-secure copy through a secure alias.
// - the whole command set is optional and may be left out.
// - status bit 0 shows a translation outstanding until the result is written.
//
// The AHB-Lite register port and the placing of the registers are this design's own decisions.
module xlate_ops
  import xlate_ops_pkg::*;
#(
  parameter bit WIDE = 1'b1,
  parameter bit XLATE_PRESENT = 1'b1,
  parameter int unsigned IA_W = WIDE ? WIDE_IA_W : NARROW_IA_W
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hnonsec,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // request to the translation engine
  output logic req_valid,
  input wire logic req_ready,
  output logic [IA_W-1:0] req_addr,
  output logic [7:0] req_ndx,
  output logic req_stage2,
  output logic req_priv,
  output logic req_write,
  output logic req_nonsec,
  // result from the translation engine
  input wire logic res_valid,
  input wire logic [63:0] res_data
);

  // ==========================================================================
  // state and decode
  state_s s_q;
  state_s s_d;

  logic addr_ok;
  logic rd_take;
  logic rd_alias;
  logic rd_bank_ok;
  logic rd_bank;
  logic [7:0] rd_view;
  logic wr_alias;
  logic wr_bank_ok;
  logic wr_bank;
  logic [7:0] wr_view;
  logic cmd_write;
  logic cmd_hi;
  logic cmd_lo;
  logic cmd_start;
  logic [2:0] cmd_idx;

  assign addr_ok = hsel && hready && (htrans == HTRANS_NONSEQ);
  assign rd_take = addr_ok && !hwrite;
  assign rd_alias = haddr[OFS_ALIAS_BIT];
  assign rd_view = {2'b00, haddr[5:0]};
  // the alias window belongs to secure software only
  assign rd_bank_ok = !(rd_alias && hnonsec) && !haddr[OFS_OUT_BIT];
  assign rd_bank = rd_alias ? BANK_NS : hnonsec;

  assign wr_alias = s_q.wr_off[OFS_ALIAS_BIT];
  assign wr_view = {2'b00, s_q.wr_off[5:0]};
  assign wr_bank_ok = !(wr_alias && s_q.wr_ns) && !s_q.wr_off[OFS_OUT_BIT];
  assign wr_bank = wr_alias ? BANK_NS : s_q.wr_ns;
  assign cmd_idx = wr_view[CMD_IDX_LSB +: 3];
  // an absent command set accepts writes and ignores them
  assign cmd_write = s_q.wr_pend && wr_bank_ok && XLATE_PRESENT && (wr_view < OFS_CMD_END);
  assign cmd_hi = cmd_write && wr_view[CMD_HI_BIT];
  assign cmd_lo = cmd_write && !wr_view[CMD_HI_BIT];
  // a command during an active one is dropped; result stays that of the first
  assign cmd_start = cmd_lo && (s_q.eng == ENG_IDLE);

  // ==========================================================================
  // next state
  always_comb begin
    s_d = s_q;
    // bus: latch the write address phase, write data follows a cycle later
    s_d.wr_pend = addr_ok && hwrite;
    if (addr_ok && hwrite) begin
      s_d.wr_off = haddr[7:0];
      s_d.wr_ns = hnonsec;
    end
    // read data is produced at the address phase so it stands in the data phase
    if (rd_take) begin
      s_d.rdata = RDATA_RST;
      if (rd_bank_ok && XLATE_PRESENT) begin
        case (rd_view)
          OFS_RESULT_LO: begin
            s_d.rdata = rd_bank ? s_q.res_ns[31:0] : s_q.res_sec[31:0];
          end
          OFS_RESULT_HI: begin
            s_d.rdata = rd_bank ? s_q.res_ns[63:32] : s_q.res_sec[63:32];
          end
          OFS_STATUS: begin
            s_d.rdata[STATUS_ACTIVE_BIT] = s_q.active[rd_bank];
          end
          default: begin
            s_d.rdata = RDATA_RST;
          end
        endcase
      end
    end
    // engine handshake
    case (s_q.eng)
      ENG_IDLE: begin
        if (cmd_start) begin
          // the 32-bit word is the whole command: upper half is zero
          s_d.req_addr = {{(WIDE_IA_W - 20){1'b0}}, hwdata[31:ADDR_LSB]};
          s_d.req_ndx = hwdata[NDX_MSB:0];
          s_d.req_cmd = cmd_e'(cmd_idx);
          s_d.req_bank = wr_bank;
          s_d.active[wr_bank] = 1'b1;
          s_d.eng = ENG_REQ;
        end
      end
      ENG_REQ: begin
        if (req_ready) begin
          s_d.eng = ENG_WAIT;
        end
      end
      ENG_WAIT: begin
        if (res_valid) begin
          if (s_q.req_bank) begin
            s_d.res_ns = res_data;
          end else begin
            s_d.res_sec = res_data;
          end
          s_d.active[s_q.req_bank] = 1'b0;
          s_d.eng = ENG_IDLE;
        end
      end
      default: begin
        s_d.eng = ENG_IDLE;
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_q <= '{
        wr_pend: 1'b0,
        wr_off: 8'h00,
        wr_ns: 1'b0,
        rdata: RDATA_RST,
        eng: ENG_IDLE,
        active: ACTIVE_RST,
        res_sec: RESULT_RST,
        res_ns: RESULT_RST,
        req_bank: BANK_SEC,
        req_addr: '0,
        req_ndx: 8'h00,
        req_cmd: CMD_S1_PRIV_READ
      };
    end else begin
      s_q <= s_d;
    end
  end

  // ==========================================================================
  // outputs
  assign hrdata = s_q.rdata;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign req_valid = (s_q.eng == ENG_REQ);
  assign req_addr = s_q.req_addr[IA_W-1:0];
  assign req_ndx = s_q.req_ndx;
  assign req_nonsec = s_q.req_bank;
  // command attributes: stage, privilege and direction
  assign req_stage2 = (s_q.req_cmd == CMD_S12_PRIV_READ) || (s_q.req_cmd == CMD_S12_PRIV_WRITE);
  assign req_priv = (s_q.req_cmd != CMD_S1_UNPRIV_READ) && (s_q.req_cmd != CMD_S1_UNPRIV_WRITE);
  assign req_write = s_q.req_cmd[0];

  // ==========================================================================
  // assertions
  logic [2:0] exp_cmd_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      exp_cmd_q <= 3'h0;
    end else if (cmd_start) begin
      exp_cmd_q <= cmd_idx;
    end
  end

  a_low_write_addr: assert property (
    @(posedge hclk) disable iff (!hresetn)
    cmd_start |=> req_valid && (s_q.req_addr == {32'h0, $past(hwdata[31:12])}))
    else $error("low word write did not start a zero-extended request");

  a_high_write_none: assert property (
    @(posedge hclk) disable iff (!hresetn)
    cmd_hi && !res_valid |=> (s_q.active == $past(s_q.active)) && (s_q.eng == $past(s_q.eng) || req_ready))
    else $error("high word write changed the engine");

  a_bank_index: assert property (
    @(posedge hclk) disable iff (!hresetn)
    cmd_start |=> (req_ndx == $past(hwdata[7:0])) && (req_nonsec == $past(wr_bank)))
    else $error("context bank index or bank not passed");

  a_attr_stage: assert property (
    @(posedge hclk) disable iff (!hresetn)
    req_valid |-> req_stage2 == (exp_cmd_q[2] == 1'b1) && req_write == exp_cmd_q[0])
    else $error("stage or direction attribute wrong");

  a_attr_priv: assert property (
    @(posedge hclk) disable iff (!hresetn)
    req_valid |-> req_priv == !(exp_cmd_q == 3'h2 || exp_cmd_q == 3'h3))
    else $error("privilege attribute wrong");

  a_active_held: assert property (
    @(posedge hclk) disable iff (!hresetn)
    $rose(req_valid) |-> s_q.active[req_nonsec] throughout (s_q.eng != ENG_IDLE)[*1])
    else $error("status not active while request outstanding");

  a_result_store: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (s_q.eng == ENG_WAIT) && res_valid |=>
      !s_q.active[$past(req_nonsec)] && ((req_nonsec ? s_q.res_ns : s_q.res_sec) == $past(res_data)))
    else $error("result not stored or status not cleared");

  a_cmd_read_zero: assert property (
    @(posedge hclk) disable iff (!hresetn)
    rd_take && (rd_view < OFS_CMD_END) && !res_valid && !cmd_start |=>
      (hrdata == 32'h0) && $stable(s_q.active))
    else $error("command register read not zero");

  a_busy_drop: assert property (
    @(posedge hclk) disable iff (!hresetn)
    cmd_lo && (s_q.eng != ENG_IDLE) |=> $stable(s_q.req_addr) && $stable(s_q.req_ndx))
    else $error("command during active one changed the request");

  a_absent_quiet: assert property (
    @(posedge hclk) disable iff (!hresetn)
    !XLATE_PRESENT |-> !req_valid)
    else $error("request issued with command set absent");

  // ==========================================================================
  // engine handshake, status, bank selection, attribute and read data checks
  a_one_outstanding: assert property (
    @(posedge hclk) disable iff (!hresetn)
    !(s_q.active[0] && s_q.active[1]))
    else $error("two translations outstanding at once");

  a_req_hold: assert property (
    @(posedge hclk) disable iff (!hresetn)
    req_valid && !req_ready |=>
      req_valid && $stable(req_addr) && $stable(req_ndx) && $stable(req_nonsec))
    else $error("request dropped or changed before acceptance");

  a_accept_clear: assert property (
    @(posedge hclk) disable iff (!hresetn)
    req_valid && req_ready |=>
      !req_valid && (s_q.eng == ENG_WAIT))
    else $error("accepted request not withdrawn");

  a_result_ignored: assert property (
    @(posedge hclk) disable iff (!hresetn)
    res_valid && (s_q.eng != ENG_WAIT) |=>
      $stable(s_q.res_sec) && $stable(s_q.res_ns))
    else $error("result taken with no translation waiting");

  a_status_set: assert property (
    @(posedge hclk) disable iff (!hresetn)
    cmd_start |=>
      s_q.active[req_nonsec] && (s_q.eng == ENG_REQ))
    else $error("status not raised by a command");

  a_status_read: assert property (
    @(posedge hclk) disable iff (!hresetn)
    rd_take && rd_bank_ok && XLATE_PRESENT && (rd_view == OFS_STATUS) |=>
      hrdata == {31'h0, $past(s_q.active[rd_bank])})
    else $error("status read does not show the active flag");

  a_copy_select: assert property (
    @(posedge hclk) disable iff (!hresetn)
    cmd_start && !wr_alias |=>
      req_nonsec == $past(s_q.wr_ns))
    else $error("command copy does not follow the access security");

  a_alias_select: assert property (
    @(posedge hclk) disable iff (!hresetn)
    cmd_start && wr_alias |=>
      req_nonsec && $past(!s_q.wr_ns))
    else $error("alias write did not reach the non-secure copy");

  a_alias_ns_quiet: assert property (
    @(posedge hclk) disable iff (!hresetn)
    s_q.wr_pend && wr_alias && s_q.wr_ns |=>
      !$rose(req_valid))
    else $error("non-secure alias write started a translation");

  a_upper_zero: assert property (
    @(posedge hclk) disable iff (!hresetn)
    req_valid |->
      s_q.req_addr[WIDE_IA_W-1:NARROW_IA_W] == '0)
    else $error("upper input address bits not zero");

  a_high_no_start: assert property (
    @(posedge hclk) disable iff (!hresetn)
    cmd_hi |=>
      !$rose(req_valid))
    else $error("high word write started a translation");

  a_s1_only: assert property (
    @(posedge hclk) disable iff (!hresetn)
    req_valid && (exp_cmd_q == 3'h0) |->
      !req_stage2 && req_priv && !req_write)
    else $error("stage 1 privileged read attributes wrong");

  a_s12_attr: assert property (
    @(posedge hclk) disable iff (!hresetn)
    req_valid && exp_cmd_q[2] |->
      req_stage2 && req_priv)
    else $error("combined stage command attributes wrong");

  a_priv_write: assert property (
    @(posedge hclk) disable iff (!hresetn)
    req_valid && (exp_cmd_q == 3'h1 || exp_cmd_q == 3'h5) |->
      req_write && req_priv)
    else $error("privileged write attributes wrong");

  a_unpriv_attr: assert property (
    @(posedge hclk) disable iff (!hresetn)
    req_valid && (exp_cmd_q == 3'h2 || exp_cmd_q == 3'h3) |->
      !req_stage2 && !req_priv && (req_write == exp_cmd_q[0]))
    else $error("unprivileged command attributes wrong");

  a_busy_status: assert property (
    @(posedge hclk) disable iff (!hresetn)
    cmd_lo && (s_q.eng == ENG_REQ) |=>
      $stable(s_q.active) && $stable(s_q.req_cmd))
    else $error("command during active one changed the status");

  a_unmapped_zero: assert property (
    @(posedge hclk) disable iff (!hresetn)
    rd_take && haddr[OFS_OUT_BIT] |=>
      hrdata == 32'h0)
    else $error("unmapped read not zero");

  a_rdata_stand: assert property (
    @(posedge hclk) disable iff (!hresetn)
    !rd_take |=>
      $stable(hrdata))
    else $error("read data changed without a read");

  a_absent_read_zero: assert property (
    @(posedge hclk) disable iff (!hresetn)
    rd_take && !XLATE_PRESENT |=>
      hrdata == 32'h0)
    else $error("read not zero with command set absent");

  c_translate: cover property (@(posedge hclk) disable iff (!hresetn) cmd_start ##[1:20] res_valid);
  c_alias_write: cover property (@(posedge hclk) disable iff (!hresetn) cmd_start && wr_alias);
  c_high_write: cover property (@(posedge hclk) disable iff (!hresetn) cmd_hi);
  c_busy_write: cover property (@(posedge hclk) disable iff (!hresetn) cmd_lo && (s_q.eng != ENG_IDLE));
  c_ns_result: cover property (@(posedge hclk) disable iff (!hresetn)
    res_valid && req_nonsec && (s_q.eng == ENG_WAIT));

endmodule : xlate_ops

// file: verif/tb_global_address_translation_ops.sv
// self-checking bench for the global address translation command bank
module tb_global_address_translation_ops import xlate_ops_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================================================
  // signals
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, hnonsec = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic req_ready = 1'b0, res_valid = 1'b0;
  logic [63:0] res_data = 64'h0;
  logic [31:0] hrdata, hrdata_x, w, r;
  logic hready, hreadyout, hresp, req_valid, req_valid_x, req_stage2, req_priv, req_write, req_nonsec;
  logic [WIDE_IA_W-1:0] req_addr;
  logic [7:0] req_ndx;
  logic [63:0] res;
  int n_fail = 0, samples_checked = 0;
  assign hready = hreadyout;
  always #5 hclk = ~hclk;
  xlate_ops dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hnonsec(hnonsec), .hready(hready), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .req_valid(req_valid), .req_ready(req_ready), .req_addr(req_addr), .req_ndx(req_ndx),
    .req_stage2(req_stage2), .req_priv(req_priv), .req_write(req_write), .req_nonsec(req_nonsec),
    .res_valid(res_valid), .res_data(res_data));
  // a second copy without the command set watches the same bus
  xlate_ops #(.XLATE_PRESENT(1'b0)) dut_absent (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hnonsec(hnonsec), .hready(hready), .hwdata(hwdata),
    .hrdata(hrdata_x), .hreadyout(), .hresp(), .req_valid(req_valid_x), .req_ready(req_ready), .req_addr(),
    .req_ndx(), .req_stage2(), .req_priv(), .req_write(), .req_nonsec(), .res_valid(res_valid),
    .res_data(res_data));
  // ==========================================================================
  // tasks
  task automatic stop_test();
    $display("checks %0d failures %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : stop_test
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // waits at most 20 edges for hready; a bus that never answers ends the run
  task automatic wait_ready();
    int k;
    k = 0;
    do begin
      @(posedge hclk);
      k++;
    end while (hready !== 1'b1 && k < 20);
    if (hready !== 1'b1) begin
      n_fail++;
      stop_test();
    end
  endtask : wait_ready
  task automatic bus(input logic wr, input logic [7:0] a, input logic ns, input logic [31:0] d,
                     output logic [31:0] rd);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    haddr <= {24'h0, a};
    hwrite <= wr;
    hnonsec <= ns;
    wait_ready();
    htrans <= 2'h0;
    hwdata <= wr ? d : 32'h0;
    wait_ready();
    rd = hrdata;
    hsel <= 1'b0;
  endtask : bus
  // engine side: accept the request, then return one result pulse
  task automatic engine(input logic [63:0] d);
    int k;
    for (k = 0; k < 20 && req_valid !== 1'b1; k++) begin
      @(negedge hclk);
    end
    if (req_valid !== 1'b1) begin
      n_fail++;
      stop_test();
    end
    @(posedge hclk);
    req_ready <= 1'b1;
    @(posedge hclk);
    req_ready <= 1'b0;
    res_valid <= 1'b1;
    res_data <= d;
    @(posedge hclk);
    res_valid <= 1'b0;
    res_data <= ~d;
    @(negedge hclk);
  endtask : engine
  // ==========================================================================
  // sequence
  initial begin
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    @(negedge hclk);
    check(req_valid, 0);
    check(req_priv, 1);
    check(hresp, 0);
    check(hready, 1);
    // every command, secure copy, with reserved bits set
    for (int i = 0; i < NUM_CMDS; i++) begin
      w = {20'h8a5c0 + 20'(i), 4'hf, 8'h30 + 8'(i)};
      bus(1'b1, 8'(i * 8), 1'b0, w, r);
      @(negedge hclk);
      check(req_valid, 1);
      check(req_valid_x, 0);
      check(64'(req_addr), {44'h0, w[31:12]});
      check(req_ndx, w[7:0]);
      check(req_stage2, i >= 4);
      check(req_priv, !(i == 2 || i == 3));
      check(req_write, i % 2);
      check(req_nonsec, 0);
      bus(1'b0, 8'(i * 8), 1'b0, 32'h0, r);
      check(r, 0);
      bus(1'b0, OFS_STATUS, 1'b0, 32'h0, r);
      check(r, 1);
      check(hrdata_x, 0);
      // a second command while active is dropped
      bus(1'b1, 8'(i * 8), 1'b0, w ^ 32'hfff000ff, r);
      @(negedge hclk);
      check(req_ndx, w[7:0]);
      res = {32'h5a000000 | 32'(i), 32'h12340000 | 32'(i)};
      engine(res);
      bus(1'b0, OFS_STATUS, 1'b0, 32'h0, r);
      check(r, 0);
      bus(1'b0, OFS_RESULT_LO, 1'b0, 32'h0, r);
      check(r, res[31:0]);
      bus(1'b0, OFS_RESULT_HI, 1'b0, 32'h0, r);
      check(r, res[63:32]);
    end
    // high word write does nothing
    bus(1'b1, 8'h04, 1'b0, w, r);
    repeat (2) @(negedge hclk);
    check(req_valid, 0);
    // non-secure copy from a non-secure access
    bus(1'b1, 8'h10, 1'b1, 32'h00abc07e, r);
    @(negedge hclk);
    check(req_nonsec, 1);
    bus(1'b0, OFS_STATUS, 1'b0, 32'h0, r);
    check(r, 0);
    engine(64'hfeed0000beef0001);
    bus(1'b0, OFS_RESULT_LO, 1'b1, 32'h0, r);
    check(r, 32'hbeef0001);
    bus(1'b0, OFS_RESULT_LO, 1'b0, 32'h0, r);
    check(r, res[31:0]);
    // secure alias reaches the non-secure copy; non-secure use of it is ignored
    bus(1'b1, 8'h48, 1'b0, 32'h00fed001, r);
    @(negedge hclk);
    check(req_nonsec, 1);
    check(req_write, 1);
    engine(64'h1);
    bus(1'b1, 8'h48, 1'b1, 32'h00fed001, r);
    repeat (2) @(negedge hclk);
    check(req_valid, 0);
    bus(1'b0, 8'h80, 1'b0, 32'h0, r);
    check(r, 0);
    // a result pulse with no translation outstanding is ignored
    @(posedge hclk);
    res_valid <= 1'b1;
    res_data <= 64'hdead0000dead0000;
    @(posedge hclk);
    res_valid <= 1'b0;
    bus(1'b0, OFS_RESULT_LO, 1'b0, 32'h0, r);
    check(r, res[31:0]);
    // reset in mid translation clears request, status and results
    bus(1'b1, 8'h00, 1'b0, 32'h00123045, r);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(negedge hclk);
    check(req_valid, 0);
    bus(1'b0, OFS_STATUS, 1'b0, 32'h0, r);
    check(r, 0);
    bus(1'b0, OFS_RESULT_LO, 1'b0, 32'h0, r);
    check(r, 0);
    stop_test();
  end
endmodule : tb_global_address_translation_ops
